// ---- core/ssm_map.vh ----
// Register map, field positions, reset values and timing counts
// for the synchronous serial EEPROM master.
// Assumes inclusion by bare name from the core directory.
`ifndef SSM_MAP_VH
`define SSM_MAP_VH

// Register indexes on the 4-bit register port
`define SSM_REG_TX_BUFFER 4'h0
`define SSM_REG_RX_BUFFER 4'h1
`define SSM_REG_BIT_RATE_DIVIDER 4'h2
`define SSM_REG_SERIAL_MODE 4'h3
`define SSM_REG_TRANSFER_CONTROL_0 4'h4
`define SSM_REG_TRANSFER_CONTROL_1 4'h5
`define SSM_REG_SPECIAL_MODE_1 4'h6
`define SSM_REG_SPECIAL_MODE_2 4'h7
`define SSM_REG_SPECIAL_MODE_3 4'h8
`define SSM_REG_SPECIAL_MODE_4 4'h9
`define SSM_REG_TX_REQUEST_CONTROL 4'hA
`define SSM_REG_PORT_CONTROL 4'hB
`define SSM_REG_CS_WAIT 4'hC

// serial_mode_reg fields
`define SSM_MODE_SYNC 3'h1
`define SSM_MR_CLKSRC 3
`define SSM_MR_IOINV 7
// transfer_control_0 fields
`define SSM_C0_BAUDSRC_LO 0
`define SSM_C0_HSFUNC 2
`define SSM_C0_SHIFTEMPTY 3
`define SSM_C0_HSDIS 4
`define SSM_C0_OPENDRAIN 5
`define SSM_C0_EDGESEL 6
`define SSM_C0_MSBFIRST 7
// transfer_control_1 fields
`define SSM_C1_TXALLOW 0
`define SSM_C1_TXEMPTY 1
`define SSM_C1_RXALLOW 2
`define SSM_C1_RXDONE 3
`define SSM_C1_CAUSE 4
`define SSM_C1_CONTRX 5
`define SSM_C1_DATAINV 6
// rx_buffer read fields
`define SSM_RB_OVERRUN 12
// tx_request_control fields
`define SSM_TRC_PEND 3
// port_control fields
`define SSM_PC_CS 0
`define SSM_PC_SCLK 1
`define SSM_PC_TXD 2
`define SSM_PC_RXD 3
`define SSM_PC_RXDDRV 4

// Reset values
`define SSM_RST_BYTE 8'h00
`define SSM_RST_PORT 5'h0F
`define SSM_RST_WAIT 8'h00

// Prescaler terminal counts for the four count sources, and the select wait counter ceiling
`define SSM_PRE_DIV1 6'h00
`define SSM_PRE_DIV8 6'h07
`define SSM_PRE_DIV32 6'h1F
`define SSM_PRE_DIV64 6'h3F
`define SSM_WAIT_MAX 8'hFF

`endif

// ---- core/ssm_master.v ----
// Synchronous serial master for a serial EEPROM, with register port,
// chip select port bit, bit-rate generator and shift engine.
// Assumes a single-cycle register master on clk and an external
// serial clock that is asynchronous to clk.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "ssm_map.vh"

module ssm_master #(
  parameter DIV_W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire [3:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdata,
  output reg csOut,
  output reg sclkOut,
  output reg sclkOe,
  input wire sclkIn,
  output reg txdOut,
  output reg txdOe,
  input wire rxdIn,
  output reg rxdOut,
  output reg rxdOe,
  output wire dmaTxReq
);

////////////////////////////////////////////////////////////////////////
// Register state

reg [2:0] modeField;
reg clkSrcExt;
reg ioInv;
reg [7:0] special1;
reg [7:0] special2;
reg [7:0] special3;
reg [7:0] special4;
reg [DIV_W-1:0] rateDiv;
reg [1:0] baudSrc;
reg hsFunc;
reg hsDis;
reg openDrain;
reg edgeSel;
reg msbFirst;
reg txAllow;
reg rxAllow;
reg causeSel;
reg contRx;
reg dataInv;
reg [2:0] prioLevel;
reg pendReq;
reg [7:0] txBuf;
reg txBufEmpty;
reg [7:0] rxBuf;
reg rxComplete;
reg overrun;
reg [4:0] portCtrl;
reg [7:0] csWait;

////////////////////////////////////////////////////////////////////////
// Engine state

reg busy;
reg [7:0] shifter;
reg [2:0] bitCnt;
reg sclkLvl;
reg txBit;
reg [5:0] preCnt;
reg [DIV_W-1:0] divCnt;
reg [7:0] csLowCnt;
reg [7:0] holdCnt;
reg sclkSync1;
reg sclkSync2;
reg sclkPrev;
reg rxdSync1;
reg rxdSync2;

wire wrHit;
wire rdRxBuf;
wire serialOn;
wire idleLvl;
wire preTick;
wire halfTick;
wire extChange;
wire leadEdge;
wire trailEdge;
wire setupDone;
wire startByte;
wire lastBit;
wire byteDone;
wire rxBit;
wire reqEvent;
reg [5:0] preTerm;
reg [7:0] nextShift;
reg [15:0] next_rdata;

assign wrHit = regWr;
assign rdRxBuf = regRd && (regAddr == `SSM_REG_RX_BUFFER);
assign serialOn = (modeField == `SSM_MODE_SYNC);
// Idle level is high with the edge bit at 0, so the first edge falls
assign idleLvl = ~edgeSel;

////////////////////////////////////////////////////////////////////////
// Bit-rate generator

always @* begin
  case (baudSrc)
    2'h0: preTerm = `SSM_PRE_DIV1;
    2'h1: preTerm = `SSM_PRE_DIV8;
    2'h2: preTerm = `SSM_PRE_DIV32;
    default: preTerm = `SSM_PRE_DIV64;
  endcase
end

assign preTick = (preCnt == preTerm);
// Half a clock period is (divider + 1) count-source ticks
assign halfTick = preTick && (divCnt == rateDiv);

always @(posedge clk) begin
  if (!rst_n || !busy) begin
    preCnt <= 6'h00;
    divCnt <= {DIV_W{1'b0}};
  end else if (preTick) begin
    preCnt <= 6'h00;
    if (divCnt == rateDiv) begin
      divCnt <= {DIV_W{1'b0}};
    end else begin
      divCnt <= divCnt + 1'b1;
    end
  end else begin
    preCnt <= preCnt + 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////
// Input synchronisers; the first stage feeds only the second

always @(posedge clk) begin
  if (!rst_n) begin
    sclkSync1 <= 1'b1;
    sclkSync2 <= 1'b1;
    sclkPrev <= 1'b1;
    rxdSync1 <= 1'b1;
    rxdSync2 <= 1'b1;
  end else begin
    sclkSync1 <= sclkIn;
    sclkSync2 <= sclkSync1;
    sclkPrev <= sclkSync2;
    rxdSync1 <= rxdIn;
    rxdSync2 <= rxdSync1;
  end
end

assign extChange = (sclkSync2 != sclkPrev);

////////////////////////////////////////////////////////////////////////
// Shift engine

// With an external clock the edges come from the synchronised pin
assign leadEdge = busy && (clkSrcExt ?
    (extChange && sclkPrev == idleLvl) :
    (halfTick && sclkLvl == idleLvl));
assign trailEdge = busy && (clkSrcExt ?
    (extChange && sclkPrev != idleLvl) :
    (halfTick && sclkLvl != idleLvl));
// Select must sit low for the programmed wait before the first edge
assign setupDone = !csOut && (csLowCnt >= csWait);
assign startByte = !busy && serialOn && txAllow && !txBufEmpty &&
    setupDone;
assign lastBit = (bitCnt == 3'h7);
assign byteDone = trailEdge && lastBit;
assign rxBit = rxdSync2 ^ ioInv ^ dataInv;

always @* begin
  if (msbFirst) begin
    nextShift = {shifter[6:0], rxBit};
  end else begin
    nextShift = {rxBit, shifter[7:1]};
  end
end

always @(posedge clk) begin
  if (!rst_n) begin
    busy <= 1'b0;
    shifter <= `SSM_RST_BYTE;
    bitCnt <= 3'h0;
    sclkLvl <= 1'b1;
    txBit <= 1'b1;
  end else if (startByte) begin
    busy <= 1'b1;
    shifter <= txBuf;
    bitCnt <= 3'h0;
    sclkLvl <= idleLvl;
  end else if (leadEdge) begin
    sclkLvl <= ~idleLvl;
    txBit <= (msbFirst ? shifter[7] : shifter[0]) ^ dataInv;
  end else if (trailEdge) begin
    sclkLvl <= idleLvl;
    shifter <= nextShift;
    bitCnt <= bitCnt + 1'b1;
    if (lastBit) begin
      busy <= 1'b0;
    end
  end else if (!busy) begin
    sclkLvl <= idleLvl;
  end
end

////////////////////////////////////////////////////////////////////////
// Select timing: setup count while low, hold count after last edge

always @(posedge clk) begin
  if (!rst_n) begin
    csLowCnt <= `SSM_RST_WAIT;
    holdCnt <= `SSM_RST_WAIT;
  end else begin
    if (csOut) begin
      csLowCnt <= `SSM_RST_WAIT;
    end else if (csLowCnt != `SSM_WAIT_MAX) begin
      csLowCnt <= csLowCnt + 1'b1;
    end
    if (byteDone) begin
      holdCnt <= csWait;
    end else if (holdCnt != `SSM_RST_WAIT) begin
      holdCnt <= holdCnt - 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Transmit request and DMA request

// Cause 0: buffer handed to the shifter; cause 1: shifter emptied
assign reqEvent = causeSel ? byteDone : startByte;
assign dmaTxReq = reqEvent;

////////////////////////////////////////////////////////////////////////
// Register writes and flag updates; hardware sets win over clears, except that a transmit buffer write wins over the empty set and an rx read over overrun

always @(posedge clk) begin
  if (!rst_n) begin
    modeField <= 3'h0;
    clkSrcExt <= 1'b0;
    ioInv <= 1'b0;
    special1 <= `SSM_RST_BYTE;
    special2 <= `SSM_RST_BYTE;
    special3 <= `SSM_RST_BYTE;
    special4 <= `SSM_RST_BYTE;
    rateDiv <= {DIV_W{1'b0}};
    baudSrc <= 2'h0;
    hsFunc <= 1'b0;
    hsDis <= 1'b0;
    openDrain <= 1'b0;
    edgeSel <= 1'b0;
    msbFirst <= 1'b0;
    txAllow <= 1'b0;
    rxAllow <= 1'b0;
    causeSel <= 1'b0;
    contRx <= 1'b0;
    dataInv <= 1'b0;
    prioLevel <= 3'h0;
    pendReq <= 1'b0;
    txBuf <= `SSM_RST_BYTE;
    txBufEmpty <= 1'b1;
    rxBuf <= `SSM_RST_BYTE;
    rxComplete <= 1'b0;
    overrun <= 1'b0;
    portCtrl <= `SSM_RST_PORT;
    csWait <= `SSM_RST_WAIT;
  end else begin
    if (startByte) begin
      txBufEmpty <= 1'b1;
    end
    if (rdRxBuf) begin
      rxComplete <= 1'b0;
      overrun <= 1'b0;
    end
    if (wrHit) begin
      case (regAddr)
        `SSM_REG_TX_BUFFER: begin
          txBuf <= regWdata[7:0];
          txBufEmpty <= 1'b0;
        end
        `SSM_REG_BIT_RATE_DIVIDER: rateDiv <= regWdata[DIV_W-1:0];
        `SSM_REG_SERIAL_MODE: begin
          modeField <= regWdata[2:0];
          clkSrcExt <= regWdata[`SSM_MR_CLKSRC];
          ioInv <= regWdata[`SSM_MR_IOINV];
        end
        `SSM_REG_TRANSFER_CONTROL_0: begin
          baudSrc <= regWdata[`SSM_C0_BAUDSRC_LO+1:`SSM_C0_BAUDSRC_LO];
          hsFunc <= regWdata[`SSM_C0_HSFUNC];
          hsDis <= regWdata[`SSM_C0_HSDIS];
          openDrain <= regWdata[`SSM_C0_OPENDRAIN];
          edgeSel <= regWdata[`SSM_C0_EDGESEL];
          msbFirst <= regWdata[`SSM_C0_MSBFIRST];
        end
        `SSM_REG_TRANSFER_CONTROL_1: begin
          txAllow <= regWdata[`SSM_C1_TXALLOW];
          rxAllow <= regWdata[`SSM_C1_RXALLOW];
          causeSel <= regWdata[`SSM_C1_CAUSE];
          contRx <= regWdata[`SSM_C1_CONTRX];
          dataInv <= regWdata[`SSM_C1_DATAINV];
        end
        `SSM_REG_SPECIAL_MODE_1: special1 <= regWdata[7:0];
        `SSM_REG_SPECIAL_MODE_2: special2 <= regWdata[7:0];
        `SSM_REG_SPECIAL_MODE_3: special3 <= regWdata[7:0];
        `SSM_REG_SPECIAL_MODE_4: special4 <= regWdata[7:0];
        `SSM_REG_TX_REQUEST_CONTROL: begin
          prioLevel <= regWdata[2:0];
          if (!regWdata[`SSM_TRC_PEND]) begin
            pendReq <= 1'b0;
          end
        end
        `SSM_REG_PORT_CONTROL: portCtrl <= regWdata[4:0];
        `SSM_REG_CS_WAIT: csWait <= regWdata[7:0];
        default: begin
        end
      endcase
    end
    if (reqEvent) begin
      pendReq <= 1'b1;
    end
    if (byteDone && rxAllow) begin
      rxBuf <= nextShift;
      rxComplete <= 1'b1;
      // A byte still unread when the next lands is lost
      // A read in the same cycle has already reported the old flags
      overrun <= (overrun | rxComplete) & ~rdRxBuf;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Register reads: data in the cycle after the strobe only

always @* begin
  next_rdata = 16'h0000;
  case (regAddr)
    `SSM_REG_RX_BUFFER: begin
      next_rdata[7:0] = rxBuf;
      next_rdata[`SSM_RB_OVERRUN] = overrun;
    end
    `SSM_REG_BIT_RATE_DIVIDER: next_rdata[DIV_W-1:0] = rateDiv;
    `SSM_REG_SERIAL_MODE: begin
      next_rdata[2:0] = modeField;
      next_rdata[`SSM_MR_CLKSRC] = clkSrcExt;
      next_rdata[`SSM_MR_IOINV] = ioInv;
    end
    `SSM_REG_TRANSFER_CONTROL_0: begin
      next_rdata[`SSM_C0_BAUDSRC_LO+1:`SSM_C0_BAUDSRC_LO] = baudSrc;
      next_rdata[`SSM_C0_HSFUNC] = hsFunc;
      next_rdata[`SSM_C0_SHIFTEMPTY] = ~busy;
      next_rdata[`SSM_C0_HSDIS] = hsDis;
      next_rdata[`SSM_C0_OPENDRAIN] = openDrain;
      next_rdata[`SSM_C0_EDGESEL] = edgeSel;
      next_rdata[`SSM_C0_MSBFIRST] = msbFirst;
    end
    `SSM_REG_TRANSFER_CONTROL_1: begin
      next_rdata[`SSM_C1_TXALLOW] = txAllow;
      next_rdata[`SSM_C1_TXEMPTY] = txBufEmpty;
      next_rdata[`SSM_C1_RXALLOW] = rxAllow;
      next_rdata[`SSM_C1_RXDONE] = rxComplete;
      next_rdata[`SSM_C1_CAUSE] = causeSel;
      next_rdata[`SSM_C1_CONTRX] = contRx;
      next_rdata[`SSM_C1_DATAINV] = dataInv;
    end
    `SSM_REG_SPECIAL_MODE_1: next_rdata[7:0] = special1;
    `SSM_REG_SPECIAL_MODE_2: next_rdata[7:0] = special2;
    `SSM_REG_SPECIAL_MODE_3: next_rdata[7:0] = special3;
    `SSM_REG_SPECIAL_MODE_4: next_rdata[7:0] = special4;
    `SSM_REG_TX_REQUEST_CONTROL: begin
      next_rdata[2:0] = prioLevel;
      next_rdata[`SSM_TRC_PEND] = pendReq;
    end
    `SSM_REG_PORT_CONTROL: next_rdata[4:0] = portCtrl;
    `SSM_REG_CS_WAIT: next_rdata[7:0] = csWait;
    default: next_rdata = 16'h0000;
  endcase
end

always @(posedge clk) begin
  if (!rst_n) begin
    regRdata <= 16'h0000;
  end else if (regRd) begin
    regRdata <= next_rdata;
  end else begin
    regRdata <= 16'h0000;
  end
end

////////////////////////////////////////////////////////////////////////
// Pin drivers; port levels take over whenever serial mode is off

always @(posedge clk) begin
  if (!rst_n) begin
    csOut <= 1'b1;
    sclkOut <= 1'b1;
    sclkOe <= 1'b1;
    txdOut <= 1'b1;
    txdOe <= 1'b1;
    rxdOut <= 1'b1;
    rxdOe <= 1'b0;
  end else begin
    // Select held low while shifting and until the hold wait runs out
    csOut <= portCtrl[`SSM_PC_CS] & ~busy &
        (holdCnt == `SSM_RST_WAIT);
    if (serialOn) begin
      sclkOut <= clkSrcExt ? portCtrl[`SSM_PC_SCLK] : sclkLvl;
      sclkOe <= ~clkSrcExt;
      txdOut <= txBit ^ ioInv;
      // Open-drain drives only the low level
      txdOe <= openDrain ? ~(txBit ^ ioInv) : 1'b1;
      rxdOe <= 1'b0;
    end else begin
      sclkOut <= portCtrl[`SSM_PC_SCLK];
      sclkOe <= 1'b1;
      txdOut <= portCtrl[`SSM_PC_TXD];
      txdOe <= 1'b1;
      rxdOe <= portCtrl[`SSM_PC_RXDDRV];
    end
    rxdOut <= portCtrl[`SSM_PC_RXD];
  end
end

endmodule // ssm_master

// ---- verif/ssm_eeprom_model.sv ----
// Serial memory stand-in: takes one byte in while sending one byte out.
// Assumes the clock idles high, data changes on falling clock edges.
`timescale 1ns/10ps
module ssm_eeprom_model (
  input logic csN,
  input logic sclk,
  input logic din,
  output logic dout,
  output logic [7:0] lastRx,
  output int nBytes
);
  logic [7:0] resp = 8'hC3;
  logic [7:0] shIn;
  logic [7:0] shOut;
  int bitN;
  initial begin
    dout = 1'b0;
    nBytes = 0;
  end
  always @(negedge csN) begin
    bitN = 0;
    shOut = resp;
  end
  // Released line shows the inverse, so a stale level is never trusted
  always @(posedge csN) dout <= ~dout;
  //////////////////////////////////////////////////////////////////////////
  always @(negedge sclk) begin
    if (!csN) begin
      dout <= shOut[7];
      shOut = {shOut[6:0], 1'b0};
    end
  end
  always @(posedge sclk) begin
    if (!csN) begin
      shIn = {shIn[6:0], din};
      bitN = bitN + 1;
      if (bitN == 8) begin
        lastRx <= shIn;
        nBytes <= nBytes + 1;
        resp = resp + 8'h01;
        shOut = resp;
        bitN = 0;
      end
    end
  end
endmodule // ssm_eeprom_model

// ---- verif/ssm_master_bench.sv ----
// Bench for the serial master talking to the memory stand-in.
// Assumes a pull-up on the data output line and the register map header.
`timescale 1ns/10ps
`include "ssm_map.vh"
`define CMP(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module ssm_master_bench;
  localparam logic [7:0] DIV = 8'h03;
  localparam logic [7:0] HOLD = 8'h40;
  logic clk, rst_n, regWr, regRd;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata, d, e;
  logic csOut, sclkOut, sclkOe, txdOut, txdOe, rxdOut, rxdOe, dmaTxReq;
  logic [7:0] lastRx;
  logic extClk = 1'b1;
  int nBytes, error_cnt = 0, tests_run = 0, pulses = 0;
  wire sclk = sclkOe ? sclkOut : extClk;
  wire txd = txdOe ? txdOut : 1'b1;
  wire memOut;
  wire rxd = rxdOe ? rxdOut : memOut;
  ssm_master #(.DIV_W(8)) uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .csOut(csOut), .sclkOut(sclkOut), .sclkOe(sclkOe), .sclkIn(sclk),
    .txdOut(txdOut), .txdOe(txdOe), .rxdIn(rxd), .rxdOut(rxdOut),
    .rxdOe(rxdOe), .dmaTxReq(dmaTxReq));
  ssm_eeprom_model mem (.csN(csOut), .sclk(sclk), .din(txd), .dout(memOut),
    .lastRx(lastRx), .nBytes(nBytes));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (dmaTxReq === 1'b1) pulses <= pulses + 1;
  //////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] x);
    rd(a);
    `CMP($sformatf("reg %h", a), x, d)
  endtask
  task automatic waitBytes(input int n);
    for (int i = 0; i < 3000 && nBytes < n; i++) @(posedge clk);
    `CMP("bytes", n, nBytes)
    repeat (8) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #60000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1 `CMP("pins", 4'hF, {csOut, sclkOut, txdOut, rxdOut})
    for (int i = 2; i < 16; i++) begin
      e = (i == 4) ? 16'h0008 : (i == 5) ? 16'h0002 : 16'h0000;
      if (i == 11) e = 16'h000F;
      rc(i[3:0], e);
    end
    wr(`SSM_REG_SPECIAL_MODE_3, 16'h12A5);
    rc(`SSM_REG_SPECIAL_MODE_3, 16'h00A5);
    wr(4'hD, 16'hFFFF);
    rc(4'hD, 16'h0000);
    // Only read-only bits set, so nothing may change
    wr(`SSM_REG_TRANSFER_CONTROL_1, 16'h000A);
    rc(`SSM_REG_TRANSFER_CONTROL_1, 16'h0002);
    wr(`SSM_REG_PORT_CONTROL, 16'h000F);
    wr(`SSM_REG_BIT_RATE_DIVIDER, {8'h00, DIV});
    wr(`SSM_REG_CS_WAIT, {8'h00, HOLD});
    wr(`SSM_REG_TRANSFER_CONTROL_0, 16'h0090);
    wr(`SSM_REG_TRANSFER_CONTROL_1, 16'h0005);
    wr(`SSM_REG_SERIAL_MODE, 16'h0001);
    rc(`SSM_REG_TRANSFER_CONTROL_0, 16'h0098);
    rc(`SSM_REG_TRANSFER_CONTROL_1, 16'h0007);
    `CMP("cs", 1'b1, csOut)
    wr(`SSM_REG_PORT_CONTROL, 16'h000E);
    wr(`SSM_REG_TX_BUFFER, 16'h00A5);
    waitBytes(1);
    `CMP("sent", 8'hA5, lastRx)
    rc(`SSM_REG_TRANSFER_CONTROL_1, 16'h000F);
    rc(`SSM_REG_RX_BUFFER, 16'h00C3);
    rc(`SSM_REG_TRANSFER_CONTROL_1, 16'h0007);
    rc(`SSM_REG_TX_REQUEST_CONTROL, 16'h0008);
    wr(`SSM_REG_TX_REQUEST_CONTROL, 16'h0000);
    rc(`SSM_REG_TX_REQUEST_CONTROL, 16'h0000);
    // Second byte queued while the first shifts; first reply lost
    wr(`SSM_REG_TX_BUFFER, 16'h0001);
    d = 16'h0000;
    for (int i = 0; i < 200 && d[1] !== 1'b1; i++) begin
      rd(`SSM_REG_TRANSFER_CONTROL_1);
    end
    `CMP("tx empty", 1'b1, d[1])
    wr(`SSM_REG_TX_BUFFER, 16'h0080);
    waitBytes(3);
    `CMP("sent", 8'h80, lastRx)
    rc(`SSM_REG_RX_BUFFER, 16'h10C5);
    wr(`SSM_REG_TRANSFER_CONTROL_0, 16'h0010);
    wr(`SSM_REG_TX_BUFFER, 16'h0001);
    waitBytes(4);
    `CMP("sent", 8'h80, lastRx)
    rc(`SSM_REG_RX_BUFFER, 16'h0063);
    `CMP("dma", 4, pulses)
    // Slow count source, open-drain data, request at byte end
    wr(`SSM_REG_TRANSFER_CONTROL_0, 16'h00B1);
    wr(`SSM_REG_TRANSFER_CONTROL_1, 16'h0015);
    wr(`SSM_REG_TX_BUFFER, 16'h005A);
    rc(`SSM_REG_TRANSFER_CONTROL_1, 16'h0017);
    `CMP("dma", 4, pulses)
    waitBytes(5);
    `CMP("sent", 8'h5A, lastRx)
    `CMP("dma", 5, pulses)
    rc(`SSM_REG_RX_BUFFER, 16'h00C7);
    // Clock from outside at 125 ns, standing high outside the frame
    wr(`SSM_REG_SERIAL_MODE, 16'h0009);
    wr(`SSM_REG_TX_BUFFER, 16'h003C);
    rc(`SSM_REG_TRANSFER_CONTROL_1, 16'h0017);
    `CMP("sclk oe", 1'b0, sclkOe)
    repeat (8) begin
      #62.5 extClk = 1'b0;
      #62.5 extClk = 1'b1;
    end
    waitBytes(6);
    `CMP("sent", 8'h3C, lastRx)
    `CMP("dma", 6, pulses)
    rc(`SSM_REG_RX_BUFFER, 16'h00C8);
    wr(`SSM_REG_PORT_CONTROL, 16'h000F);
    #1 `CMP("cs", 1'b0, csOut)
    repeat (80) @(posedge clk);
    #1 `CMP("cs", 1'b1, csOut)
    wr(`SSM_REG_SERIAL_MODE, 16'h0000);
    repeat (2) @(posedge clk);
    #1 `CMP("pins", 4'hF, {csOut, sclkOut, txdOut, rxdOut})
    report_and_stop();
  end
endmodule // ssm_master_bench

// ---- verif/ssm_master_chk.sv ----
// Checker for the serial master: read timing, clock timing, select waits.
// Assumes it is bound to every master and sees only its ports.
`timescale 1ns/10ps
`include "ssm_map.vh"
module ssm_master_chk #(
  parameter DIV_W = 8
) (
  input logic clk,
  input logic rst_n,
  input logic [3:0] regAddr,
  input logic [15:0] regWdata,
  input logic regWr,
  input logic regRd,
  input logic [15:0] regRdata,
  input logic csOut,
  input logic sclkOut,
  input logic sclkOe,
  input logic sclkIn,
  input logic txdOut,
  input logic txdOe,
  input logic rxdIn,
  input logic rxdOut,
  input logic rxdOe,
  input logic dmaTxReq
);
  logic [7:0] waitReg;
  logic [7:0] divReg;
  logic [1:0] srcReg;
  logic odReg;
  logic prevSclk;
  logic prevCs;
  logic [15:0] sinceCs;
  logic [15:0] sinceRise;
  logic [15:0] sinceFall;
  logic [15:0] half;
  function automatic logic [15:0] inc(input logic [15:0] v);
    inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction
  always_comb begin
    half = ({8'h00, divReg} + 16'h0001) << ((srcReg == 2'h0) ? 0 :
      (srcReg == 2'h1) ? 3 : (srcReg == 2'h2) ? 5 : 6);
  end
  // Mirror of the timing registers; counters saturate so idle time is safe
  always @(posedge clk) begin
    if (!rst_n) begin
      waitReg <= 8'h00;
      divReg <= 8'h00;
      srcReg <= 2'h0;
      odReg <= 1'b0;
      prevSclk <= 1'b1;
      prevCs <= 1'b1;
      sinceCs <= 16'h0000;
      sinceRise <= 16'hFFFF;
      sinceFall <= 16'h0000;
    end else begin
      prevSclk <= sclkOut;
      prevCs <= csOut;
      sinceCs <= (prevCs && !csOut) ? 16'h0001 : inc(sinceCs);
      sinceRise <= (!prevSclk && sclkOut) ? 16'h0001 : inc(sinceRise);
      sinceFall <= (prevSclk && !sclkOut) ? 16'h0001 : inc(sinceFall);
      if (regWr && regAddr == `SSM_REG_CS_WAIT) waitReg <= regWdata[7:0];
      if (regWr && regAddr == `SSM_REG_BIT_RATE_DIVIDER) begin
        divReg <= regWdata[7:0];
      end
      if (regWr && regAddr == `SSM_REG_TRANSFER_CONTROL_0) begin
        srcReg <= regWdata[1:0];
        odReg <= regWdata[5];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence reqPulse;
    !csOut ##1 !dmaTxReq;
  endsequence
  chk_read_stands: assert property (!regRd |=> regRdata == 16'h0000)
    else $error("read data left standing");
  chk_tx_on_fall: assert property (
    !csOut && sclkOe && $changed(txdOut) |-> $fell(sclkOut))
    else $error("data changed off the falling clock edge");
  // Outside clock: data may only move while that clock is low
  chk_ext_tx_low: assert property (
    !csOut && !sclkOe && $changed(txdOut) |-> !sclkIn)
    else $error("data changed while the outside clock was high");
  chk_open_drain: assert property (
    !csOut && odReg && $stable(odReg) && txdOe |-> !txdOut)
    else $error("open-drain output drove a high level");
  chk_half_rise: assert property (
    !csOut && $rose(sclkOut) |-> sinceFall == half)
    else $error("clock low phase differs from divider setting");
  chk_lead_wait: assert property (
    !csOut && $fell(sclkOut) |-> sinceCs >= {8'h00, waitReg})
    else $error("first clock edge too soon after select fell");
  chk_tail_wait: assert property (
    $rose(csOut) |-> sinceRise >= {8'h00, waitReg})
    else $error("select rose too soon after last clock edge");
  chk_cs_rise_idle: assert property ($rose(csOut) |-> sclkOut)
    else $error("select rose with clock low");
  chk_dma_pulse: assert property (dmaTxReq |-> reqPulse)
    else $error("transfer request not a single pulse");
  chk_push_pull: assert property (!csOut && !odReg |-> txdOe)
    else $error("data output not driven in push-pull mode");
endmodule // ssm_master_chk
bind ssm_master ssm_master_chk #(.DIV_W(DIV_W)) chk (.clk(clk),
  .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .csOut(csOut), .sclkOut(sclkOut),
  .sclkOe(sclkOe), .sclkIn(sclkIn), .txdOut(txdOut), .txdOe(txdOe),
  .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe), .dmaTxReq(dmaTxReq));
